//--- slfr_frame_receiver.sv
// receive frame state machine with its receive FIFO toward the transport
// assumes phy dwords are synchronous to clk; phy ready is asynchronous

`timescale 1ns/1ps

//==============================================================
// receive fifo with registered output stage
module slfr_fifo
   import slfr_pkg::*;
#(
   parameter int WIDTH = DWORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     inValid,
   output logic                          inReady,
   input  wire logic [WIDTH-1:0]         inData,
   output logic                          outValid,
   input  wire logic                     outReady,
   output logic [WIDTH-1:0]              outData,
   output logic [$clog2(DEPTH):0]        level
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("fifo depth must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   logic             outValid_reg;
   logic [WIDTH-1:0] outData_reg;

   wire logic doWrite = inValid && inReady;
   wire logic doLoad  = (count_reg != '0) && (!outValid_reg || outReady);
   wire logic [AW:0] countNext = count_reg
      + (doWrite ? (AW+1)'(1) : '0) - (doLoad ? (AW+1)'(1) : '0);

   assign inReady  = (count_reg != (AW+1)'(DEPTH));
   assign outValid = outValid_reg;
   assign outData  = outData_reg;
   // the output stage holds one word beyond the array
   assign level    = count_reg;

   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_reg + (doWrite ? AW'(1) : '0);
         rdPtr_reg <= rdPtr_reg + (doLoad ? AW'(1) : '0);
         count_reg <= countNext;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outValid_reg <= 1'b0;
         outData_reg  <= '0;
      end else if (doLoad) begin
         outValid_reg <= 1'b1;
         outData_reg  <= mem[rdPtr_reg];
      end else if (outReady) begin
         outValid_reg <= 1'b0;
      end
   end

endmodule // slfr_fifo

//==============================================================
// frame receiver top
module slfr_frame_receiver
   import slfr_pkg::*;
#(
   parameter int DEPTH    = FIFO_DEPTH,
   parameter int HEADROOM = FIFO_HEADROOM
) (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                phyReady,
   input  wire slfr_rx_type         rxWord,
   output slfr_prim_type            txPrim,
   input  wire logic                trnTerminate,
   input  wire logic                ctrlFramePending,
   input  wire slfr_status_type     trnStatus,
   output slfr_notify_type          notify,
   output logic                     trnValid,
   input  wire logic                trnReady,
   output logic [DWORD_W-1:0]       trnData
);
   localparam int LW = $clog2(DEPTH) + 1;

   generate
      if (HEADROOM < 1 || HEADROOM >= DEPTH) begin : g_bad_headroom
         $error("headroom must lie between 1 and depth-1");
      end
   endgenerate

   typedef enum logic [3:0] {
      IDLE_STATE, WAIT_FOR_FIFO_SPACE, CHECK_READY_STATE,
      DATA_RECEPTION_STATE, HOLD_STATE, SEND_HOLD_ACK_STATE,
      END_OF_FRAME_CHECK_STATE, GOOD_CRC_STATE, GOOD_END_STATE,
      BAD_END_STATE, NO_COMMUNICATION_ERROR_STATE
   } slfr_state_type;

   function automatic logic rxIs(
      input slfr_rx_type w,
      input slfr_prim_type p);
      return w.valid && (w.prim == p);
   endfunction

   //===========================================================
   // phy ready synchroniser
   logic phyRdyMeta_reg;
   logic phyRdySync_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phyRdyMeta_reg <= 1'b0;
         phyRdySync_reg <= 1'b0;
      end else begin
         phyRdyMeta_reg <= phyReady;
         phyRdySync_reg <= phyRdyMeta_reg;
      end
   end

   //===========================================================
   // state and decoded conditions
   slfr_state_type  state_reg;
   slfr_state_type  state_next;
   slfr_prim_type   txPrim_reg;
   slfr_prim_type   txPrim_next;
   slfr_notify_type notify_reg;
   slfr_notify_type notify_next;
   logic [31:0]     crc_reg;
   logic            checkDone_reg;
   logic            fifoInReady;
   logic [LW-1:0]   fifoLevel;

   wire logic phyDown = !phyRdySync_reg;
   wire logic rxSync  = rxIs(rxWord, PRIM_SYNC);
   wire logic rxXrdy  = rxIs(rxWord, PRIM_X_RDY);
   wire logic rxSof   = rxIs(rxWord, PRIM_SOF);
   wire logic rxEof   = rxIs(rxWord, PRIM_EOF);
   wire logic rxHold  = rxIs(rxWord, PRIM_HOLD);
   wire logic rxWtrm  = rxIs(rxWord, PRIM_WTRM);
   wire logic rxData  = rxIs(rxWord, PRIM_DATA);
   wire logic rxOther = rxWord.valid && !rxHold;

   // space test keeps headroom for dwords already on the wire
   wire logic spaceOk = (LW'(DEPTH) - fifoLevel) >= LW'(HEADROOM);

   wire logic inFrame = (state_reg == DATA_RECEPTION_STATE)
      || (state_reg == HOLD_STATE)
      || (state_reg == SEND_HOLD_ACK_STATE);
   wire logic inRecv = (state_reg != IDLE_STATE)
      && (state_reg != NO_COMMUNICATION_ERROR_STATE);
   wire logic fifoWrite = inFrame && rxData && !phyDown;
   wire logic crcMatch = (crc_reg == CRC_RESIDUE);

   //===========================================================
   // next state
   always_comb begin
      state_next  = state_reg;
      notify_next = '0;
      if (inRecv && phyDown) begin
         state_next = NO_COMMUNICATION_ERROR_STATE;
         notify_next.phyNotReady = 1'b1;
      end else if (inFrame && ctrlFramePending) begin
         state_next = IDLE_STATE;
      end else begin
         case (state_reg)
            IDLE_STATE: begin
               if (rxXrdy && !phyDown) begin
                  state_next = spaceOk ? CHECK_READY_STATE
                                       : WAIT_FOR_FIFO_SPACE;
               end
            end
            WAIT_FOR_FIFO_SPACE: begin
               if (rxXrdy && spaceOk) begin
                  state_next = CHECK_READY_STATE;
               end else if (rxWord.valid && !rxXrdy) begin
                  state_next = IDLE_STATE;
                  notify_next.unexpected = 1'b1;
               end
            end
            CHECK_READY_STATE: begin
               if (rxSof) begin
                  state_next = DATA_RECEPTION_STATE;
               end else if (rxWord.valid && !rxXrdy) begin
                  state_next = IDLE_STATE;
                  notify_next.unexpected = 1'b1;
               end
            end
            DATA_RECEPTION_STATE: begin
               if (rxSync) begin
                  state_next = IDLE_STATE;
                  notify_next.aborted = 1'b1;
               end else if (rxWtrm) begin
                  state_next = BAD_END_STATE;
               end else if (rxEof) begin
                  state_next = END_OF_FRAME_CHECK_STATE;
               end else if (rxHold) begin
                  state_next = SEND_HOLD_ACK_STATE;
               end else if (!spaceOk) begin
                  state_next = HOLD_STATE;
               end
               // anything else keeps receiving
            end
            HOLD_STATE: begin
               if (rxSync) begin
                  state_next = IDLE_STATE;
                  notify_next.illegal = 1'b1;
               end else if (rxEof) begin
                  state_next = END_OF_FRAME_CHECK_STATE;
               end else if (rxHold && spaceOk) begin
                  state_next = SEND_HOLD_ACK_STATE;
               end else if (rxOther && spaceOk) begin
                  state_next = DATA_RECEPTION_STATE;
               end
            end
            SEND_HOLD_ACK_STATE: begin
               if (rxSync) begin
                  state_next = IDLE_STATE;
                  notify_next.illegal = 1'b1;
               end else if (rxEof) begin
                  state_next = END_OF_FRAME_CHECK_STATE;
               end else if (rxOther) begin
                  state_next = DATA_RECEPTION_STATE;
               end
            end
            END_OF_FRAME_CHECK_STATE: begin
               if (checkDone_reg) begin
                  state_next = crcMatch ? GOOD_CRC_STATE
                                        : BAD_END_STATE;
                  notify_next.crcGood = crcMatch;
                  notify_next.crcBad  = !crcMatch;
               end
            end
            GOOD_CRC_STATE: begin
               if (rxSync) begin
                  state_next = IDLE_STATE;
                  notify_next.illegal = 1'b1;
               end else if (trnStatus.good) begin
                  state_next = GOOD_END_STATE;
               end else if (trnStatus.unrecognized || trnStatus.error) begin
                  state_next = BAD_END_STATE;
               end
            end
            GOOD_END_STATE, BAD_END_STATE: begin
               if (rxSync) begin
                  state_next = IDLE_STATE;
               end
            end
            NO_COMMUNICATION_ERROR_STATE: begin
               if (!phyDown) begin
                  state_next = IDLE_STATE;
               end
            end
            default: begin
               state_next = IDLE_STATE;
            end
         endcase
      end
   end

   //===========================================================
   // transmitted primitive follows the state being entered
   always_comb begin
      case (state_next)
         CHECK_READY_STATE:        txPrim_next = PRIM_R_RDY;
         DATA_RECEPTION_STATE:
            txPrim_next = trnTerminate ? PRIM_DMAT : PRIM_R_IP;
         HOLD_STATE:               txPrim_next = PRIM_HOLD;
         SEND_HOLD_ACK_STATE:
            txPrim_next = trnTerminate ? PRIM_DMAT : PRIM_HOLDA;
         END_OF_FRAME_CHECK_STATE: txPrim_next = PRIM_R_IP;
         GOOD_CRC_STATE:           txPrim_next = PRIM_R_IP;
         GOOD_END_STATE:           txPrim_next = PRIM_R_OK;
         BAD_END_STATE:            txPrim_next = PRIM_R_ERR;
         // idle after a pending control frame also sends SYNC
         default:                  txPrim_next = PRIM_SYNC;
      endcase
   end

   //===========================================================
   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= IDLE_STATE;
         txPrim_reg <= TX_RESET;
         notify_reg <= '0;
      end else begin
         state_reg  <= state_next;
         txPrim_reg <= txPrim_next;
         notify_reg <= notify_next;
      end
   end

   // crc of the received CRC dword folds the remainder to the residue
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_reg <= CRC_INIT;
      end else if (state_reg == CHECK_READY_STATE && rxSof) begin
         crc_reg <= CRC_INIT;
      end else if (fifoWrite) begin
         crc_reg <= slfr_crc_step(crc_reg, rxWord.data);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         checkDone_reg <= 1'b0;
      end else begin
         checkDone_reg <= (state_reg == END_OF_FRAME_CHECK_STATE)
            && !checkDone_reg && (CRC_CHECK_CYCLES > 0);
      end
   end

   assign txPrim = txPrim_reg;
   assign notify = notify_reg;

   //===========================================================
   // receive fifo toward transport
   // a write when full is lost; the headroom is sized to prevent it
   slfr_fifo #(
      .WIDTH (DWORD_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (fifoWrite),
      .inReady  (fifoInReady),
      .inData   (rxWord.data),
      .outValid (trnValid),
      .outReady (trnReady),
      .outData  (trnData),
      .level    (fifoLevel)
   );

   //===========================================================
   // assertions
   property p_phy_down;
      @(posedge clk) disable iff (!rst_n)
      (inRecv && phyDown) |=>
         (state_reg == NO_COMMUNICATION_ERROR_STATE)
         && notify_reg.phyNotReady;
   endproperty
   a_phy_down: assert property (p_phy_down)
      else $error("phy loss did not reach no-comm error");

   property p_wait_sync;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == WAIT_FOR_FIFO_SPACE) |-> (txPrim_reg == PRIM_SYNC);
   endproperty
   a_wait_sync: assert property (p_wait_sync)
      else $error("wait state not sending sync");

   property p_wait_other;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == WAIT_FOR_FIFO_SPACE && !phyDown && rxWord.valid
         && !rxXrdy) |=> (state_reg == IDLE_STATE)
         && notify_reg.unexpected;
   endproperty
   a_wait_other: assert property (p_wait_other)
      else $error("unexpected dword in wait not reported");

   property p_low_space_hold;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == DATA_RECEPTION_STATE && !phyDown && !ctrlFramePending
         && (!rxWord.valid || rxData) && !spaceOk)
         |=> (state_reg == HOLD_STATE)
         && (txPrim_reg == PRIM_HOLD);
   endproperty
   a_low_space_hold: assert property (p_low_space_hold)
      else $error("low space did not enter hold");

   property p_wtrm_bad;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == DATA_RECEPTION_STATE && !phyDown && !ctrlFramePending
         && rxWtrm) |=> (state_reg == BAD_END_STATE)
         && (txPrim_reg == PRIM_R_ERR);
   endproperty
   a_wtrm_bad: assert property (p_wtrm_bad)
      else $error("wtrm did not end frame as bad");

   property p_sync_abort;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == DATA_RECEPTION_STATE && !phyDown && !ctrlFramePending
         && rxSync) |=> (state_reg == IDLE_STATE) && notify_reg.aborted;
   endproperty
   a_sync_abort: assert property (p_sync_abort)
      else $error("sync in data reception not reported");

   property p_crc_result;
      @(posedge clk) disable iff (!rst_n)
      $rose(state_reg == END_OF_FRAME_CHECK_STATE) && !phyDown ##1 !phyDown
         |=> (notify_reg.crcGood == (state_reg == GOOD_CRC_STATE))
         && (notify_reg.crcGood != notify_reg.crcBad);
   endproperty
   a_crc_result: assert property (p_crc_result)
      else $error("crc check result not delivered in time");

   property p_end_prims;
      @(posedge clk) disable iff (!rst_n)
      ((state_reg == GOOD_END_STATE) |-> (txPrim_reg == PRIM_R_OK))
      and ((state_reg == BAD_END_STATE) |-> (txPrim_reg == PRIM_R_ERR));
   endproperty
   a_end_prims: assert property (p_end_prims)
      else $error("end state sends wrong primitive");

   property p_data_prim;
      @(posedge clk) disable iff (!rst_n)
      (state_reg == DATA_RECEPTION_STATE) |->
         (txPrim_reg == PRIM_R_IP || txPrim_reg == PRIM_DMAT);
   endproperty
   a_data_prim: assert property (p_data_prim)
      else $error("data reception sends wrong primitive");

   property p_no_overflow;
      @(posedge clk) disable iff (!rst_n)
      fifoWrite |-> fifoInReady;
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("receive fifo overflowed");

   c_good_end: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg == GOOD_END_STATE);
   c_bad_crc: cover property (@(posedge clk) disable iff (!rst_n)
      notify_reg.crcBad);
   c_hold: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg == HOLD_STATE ##1 state_reg == DATA_RECEPTION_STATE);
   c_hold_ack: cover property (@(posedge clk) disable iff (!rst_n)
      state_reg == SEND_HOLD_ACK_STATE);

endmodule // slfr_frame_receiver

//--- slfr_pkg.sv
// receive frame state machine of a serial storage link: shared types/consts
// assumes phy-side dwords arrive already decoded, on the same clock as clk
//
// Function
// - X_RDY with too little receive FIFO space enters wait-for-FIFO-space
// - while waiting for FIFO space, transmit SYNC toward the far side
// - waiting: X_RDY with space goes to check-ready, else keep waiting
// - waiting: any non-X_RDY dword notifies transport and returns to idle
// - check-ready sends R_RDY and waits for SOF before receiving data
// - phy not ready in any receive state: notify, enter no-comm error
// - received data dwords go to transport and into the running CRC
// - data reception sends R_IP, or DMAT when transport asks to terminate
// - low FIFO space in data reception moves to hold, else stay
// - HOLD in data, or HOLD in hold with space, enters send-hold-ack
// - EOF in data, hold or send-hold-ack enters end-of-frame check
// - FIFO headroom must absorb in-flight dwords through EOF after hold
// - WTRM during data reception goes straight to bad-end
// - SYNC in data, hold, hold-ack or good-CRC: notify, back to idle
// - other dwords in data reception keep the receiver there
// - pending control frame in data/hold/hold-ack: idle, send SYNC
// - hold sends HOLD; non-HOLD with space returns to data reception
// - hold-ack sends HOLDA or DMAT; non-HOLD non-SYNC returns to data
// - after EOF send R_IP until CRC checked, notify, good-CRC or bad-end
// - good-CRC sends R_IP, waits transport status, good or bad end
// - bad-end follows CRC mismatch or transport declaring frame invalid
// - good-end sends R_OK, bad-end R_ERR, until SYNC returns to idle

package slfr_pkg;

   //==========================================================
   // sizes and counts
   localparam int DWORD_W = 32;
   localparam int FIFO_DEPTH = 16;
   // free words kept for dwords still in flight after HOLD is sent
   localparam int FIFO_HEADROOM = 4;
   localparam int CRC_CHECK_CYCLES = 1;

   //==========================================================
   // crc constants
   localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
   localparam logic [31:0] CRC_INIT = 32'h52325032;
   localparam logic [31:0] CRC_RESIDUE = 32'h00000000;

   //==========================================================
   // primitive kinds as decoded/encoded by the phy side
   typedef enum logic [3:0] {
      PRIM_DATA, PRIM_SYNC, PRIM_X_RDY, PRIM_SOF, PRIM_EOF,
      PRIM_HOLD, PRIM_HOLDA, PRIM_WTRM, PRIM_R_RDY, PRIM_R_IP,
      PRIM_R_OK, PRIM_R_ERR, PRIM_DMAT
   } slfr_prim_type;

   localparam slfr_prim_type TX_RESET = PRIM_SYNC;

   typedef struct packed {
      logic                 valid;
      slfr_prim_type        prim;
      logic [DWORD_W-1:0]   data;
   } slfr_rx_type;

   typedef struct packed {
      logic good;
      logic unrecognized;
      logic error;
   } slfr_status_type;

   typedef struct packed {
      logic crcGood;
      logic crcBad;
      logic aborted;
      logic illegal;
      logic unexpected;
      logic phyNotReady;
   } slfr_notify_type;

   function automatic logic [31:0] slfr_crc_step(
      input logic [31:0] crc,
      input logic [31:0] d);
      logic [31:0] c;
      logic        fb;
      c = crc;
      for (int i = 31; i >= 0; i--) begin
         fb = c[31] ^ d[i];
         c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
      end
      return c;
   endfunction

endpackage

//--- slfr_far_link.sv
// far transmitting link model: drives decoded dwords into the receiver
// assumes the bench calls put once per dword, from one thread only
`timescale 1ns/1ps

module slfr_far_link
   import slfr_pkg::*;
(
   input  wire logic          clk,
   input  wire slfr_prim_type txPrim,
   output slfr_rx_type        rxWord
);
   logic stuck = 1'b0;

   initial rxWord = '0;

   //==========================================================
   // one dword per edge; data is held back while the receiver holds
   task automatic put(input logic v, input slfr_prim_type p,
                      input logic [31:0] d);
      int i;
      for (i = 0; i < 400 && p == PRIM_DATA && txPrim == PRIM_HOLD;
           i++) begin
         @(posedge clk);
         rxWord <= '{1'b1, PRIM_HOLD, ~rxWord.data};
      end
      // a hold that never lifts is flagged for the bench verdict
      if (i == 400) stuck = 1'b1;
      @(posedge clk);
      // a gap carries no dword, and its data is kept moving
      rxWord <= '{v, p, v ? d : ~rxWord.data};
   endtask
endmodule // slfr_far_link

//--- slfr_frame_receiver_tb.sv
// bench: random frames, aborts, stalls and transport verdicts
// assumes the far link model answers hold and closes frames with sync
`timescale 1ns/1ps

module slfr_frame_receiver_tb
   import slfr_pkg::*;
;
   logic            clk, rst_n, phyReady, trnTerminate, ctrlFramePending;
   logic            trnValid, trnReady, stall;
   slfr_rx_type     rxWord;
   slfr_prim_type   txPrim;
   slfr_status_type trnStatus;
   slfr_notify_type notify, seen;
   logic [15:0]     primSeen;
   logic [31:0]     trnData, sent[$], got[$];
   int              miscompares, tests_run, seed;

   slfr_frame_receiver #(.DEPTH(16), .HEADROOM(4)) slfr_frame_receiver_i (
      .clk(clk), .rst_n(rst_n), .phyReady(phyReady), .rxWord(rxWord),
      .txPrim(txPrim), .trnTerminate(trnTerminate),
      .ctrlFramePending(ctrlFramePending), .trnStatus(trnStatus),
      .notify(notify), .trnValid(trnValid), .trnReady(trnReady),
      .trnData(trnData));
   slfr_far_link slfr_far_link_i (.clk(clk), .txPrim(txPrim),
      .rxWord(rxWord));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   //==========================================================
   // transport sink with random back-pressure, sticky event flags
   always @(posedge clk) begin
      trnReady <= stall ? 1'b0 : 1'($random(seed));
      if (trnValid === 1'b1 && trnReady === 1'b1) got.push_back(trnData);
      seen <= seen | notify;
      primSeen[txPrim] <= 1'b1;
   end

   task automatic test_done();
      check("linkStuck", 0, slfr_far_link_i.stuck);
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, act);
      tests_run++;
      if (act !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
      end
   endtask

   task automatic waitPrim(input slfr_prim_type p, input int n);
      for (int i = 0; i < n && txPrim !== p; i++) @(posedge clk);
      check("txPrim", p, txPrim);
      if (txPrim !== p) test_done();
   endtask

   task automatic waitSeen(input int b);
      for (int i = 0; i < 20 && seen[b] !== 1'b1; i++) @(posedge clk);
      check("notify", 1, seen[b]);
   endtask

   // reference crc worked out here, msb first, no final inversion
   function automatic logic [31:0] crcOf(input logic [31:0] q[$]);
      logic [31:0] c = CRC_INIT;
      foreach (q[k])
         for (int i = 31; i >= 0; i--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ q[k][i]) ? CRC_POLY : 32'h0);
      return c;
   endfunction

   //==========================================================
   // kinds: 0 good, 1 bad crc, 2 error, 3 unrecognized, 4 sync abort,
   // 5 terminate then wtrm, 6 phy lost, 7 control frame, 8 stall,
   // 9 abort leaving the fifo short of headroom, then X_RDY must wait
   task automatic runTest(input int kind);
      int n;
      n = (kind == 8) ? 20
        : (kind == 9) ? FIFO_DEPTH - FIFO_HEADROOM + 2
        : 1 + ($random(seed) & 7);
      sent.delete();
      @(negedge clk);
      got.delete();
      seen = '0;
      primSeen = '0;
      trnStatus <= '{kind != 2 && kind != 3, kind == 3, kind == 2};
      trnTerminate <= (kind == 5);
      stall <= (kind == 8 || kind == 9);
      if (kind == 8) fork
         begin
            repeat (80) @(posedge clk);
            stall <= 1'b0;
         end
      join_none
      slfr_far_link_i.put(1'b1, PRIM_X_RDY, 32'h0);
      slfr_far_link_i.put(1'b0, PRIM_SYNC, 32'h0);
      waitPrim(PRIM_R_RDY, 8);
      slfr_far_link_i.put(1'b1, PRIM_SOF, 32'h0);
      for (int i = 0; i < n; i++) begin
         sent.push_back($random(seed));
         slfr_far_link_i.put(1'b1, PRIM_DATA, sent[i]);
         if (i == 1) check("txPrim", kind == 5 ? PRIM_DMAT : PRIM_R_IP, txPrim);
      end
      case (kind)
         4, 9: slfr_far_link_i.put(1'b1, PRIM_SYNC, 32'h0);
         5: slfr_far_link_i.put(1'b1, PRIM_WTRM, 32'h0);
         6: phyReady <= 1'b0;
         7: ctrlFramePending <= 1'b1;
         default: begin
            sent.push_back(crcOf(sent) ^ {31'h0, kind == 1});
            slfr_far_link_i.put(1'b1, PRIM_DATA, sent[n]);
            slfr_far_link_i.put(1'b1, PRIM_EOF, 32'h0);
         end
      endcase
      slfr_far_link_i.put(1'b0, PRIM_SYNC, 32'h0);
      if (kind == 4 || kind == 9) waitSeen(3);
      if (kind == 9) begin
         slfr_far_link_i.put(1'b1, PRIM_X_RDY, 32'h0);
         slfr_far_link_i.put(1'b1, PRIM_X_RDY, 32'h0);
         slfr_far_link_i.put(1'b0, PRIM_SYNC, 32'h0);
         check("txPrim", PRIM_SYNC, txPrim);
         check("unexpected", 0, seen[1]);
         slfr_far_link_i.put(1'b1, PRIM_SYNC, 32'h0);
         waitSeen(1);
         slfr_far_link_i.put(1'b1, PRIM_X_RDY, 32'h0);
         slfr_far_link_i.put(1'b0, PRIM_SYNC, 32'h0);
         stall <= 1'b0;
         for (int i = 0; i < 200 && got.size() < sent.size(); i++)
            @(posedge clk);
         slfr_far_link_i.put(1'b1, PRIM_X_RDY, 32'h0);
         waitPrim(PRIM_R_RDY, 8);
      end
      if (kind == 5) waitPrim(PRIM_R_ERR, 8);
      if (kind == 6) waitSeen(0);
      if (kind == 7) waitPrim(PRIM_SYNC, 8);
      if (kind < 4 || kind == 8) begin
         waitPrim(kind == 0 || kind == 8 ? PRIM_R_OK : PRIM_R_ERR, 12);
         // the sticky flags lag the state by one edge
         @(posedge clk);
         check("crcGood", kind != 1, seen[5]);
         check("crcBad", kind == 1, seen[4]);
      end
      if (kind == 8) check("holdSeen", 2'b11, {primSeen[PRIM_HOLD], primSeen[PRIM_HOLDA]});
      phyReady <= 1'b1;
      ctrlFramePending <= 1'b0;
      trnTerminate <= 1'b0;
      slfr_far_link_i.put(1'b1, PRIM_SYNC, 32'h0);
      slfr_far_link_i.put(1'b0, PRIM_SYNC, 32'h0);
      waitPrim(PRIM_SYNC, 12);
      for (int i = 0; i < 200 && got.size() < sent.size(); i++) @(posedge clk);
      if (kind != 6) begin
         check("words", sent.size(), got.size());
         foreach (sent[i])
            if (i < got.size()) check("trnData", sent[i], got[i]);
      end
      $display("test kind %0d done, %0d words", kind, sent.size());
   endtask

   //==========================================================
   initial begin
      seed = 32'hb1b8e1a9;
      miscompares = 0;
      tests_run = 0;
      rst_n = 1'b0;
      phyReady = 1'b1;
      trnTerminate = 1'b0;
      ctrlFramePending = 1'b0;
      trnStatus = '0;
      stall = 1'b0;
      trnReady = 1'b0;
      seen = '0;
      primSeen = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("txPrim", PRIM_SYNC, txPrim);
      for (int k = 0; k <= 9; k++) runTest(k);
      repeat (8) runTest(int'($unsigned($random(seed)) % 10));
      test_done();
   end
endmodule // slfr_frame_receiver_tb
